// file: rtl/ubes_pkg.sv
// Package for the serial error-status and baud generator block.
// Assumes one 25 MHz system clock and an AXI4-Lite master with 32-bit data.
package ubes_pkg;

   // Register indices; byte address is four times the index
   localparam logic [15:0] UBES_IDX_MODE = 16'hff70;
   localparam logic [15:0] UBES_IDX_STATUS = 16'hff71;
   localparam logic [15:0] UBES_IDX_BAUD = 16'hff73;
   localparam logic [15:0] UBES_IDX_RXBUF = 16'hff75;
   localparam logic [15:0] UBES_IDX_IRQ_STAT = 16'hff78;
   localparam logic [15:0] UBES_IDX_IRQ_MASK = 16'hff79;

   // Reset values
   localparam logic [7:0] UBES_RST_STATUS = 8'h00;
   localparam logic [7:0] UBES_RST_BAUD = 8'h00;
   localparam logic [7:0] UBES_RST_MODE = 8'h00;
   localparam logic [7:0] UBES_RST_RXBUF = 8'h00;
   localparam logic [3:0] UBES_RST_IRQ = 4'h0;

   // Status field positions
   localparam int UBES_ST_PARITY = 2;
   localparam int UBES_ST_FRAMING = 1;
   localparam int UBES_ST_OVERRUN = 0;

   // Mode register field positions
   localparam int UBES_MD_TXE = 7;
   localparam int UBES_MD_RXE = 6;
   localparam int UBES_MD_PS_LSB = 4;
   localparam int UBES_MD_CL = 3;
   localparam int UBES_MD_SL = 2;

   // Baud control field position and source codes
   localparam int UBES_BD_SEL_LSB = 4;
   localparam logic [3:0] UBES_SEL_OSC_MAX = 4'h7;
   localparam logic [3:0] UBES_SEL_EXT = 4'h8;

   // Interrupt status bit positions
   localparam int UBES_IRQ_RXDONE = 0;
   localparam int UBES_IRQ_PARITY = 1;
   localparam int UBES_IRQ_FRAMING = 2;
   localparam int UBES_IRQ_OVERRUN = 3;

   // Bus responses
   localparam logic [1:0] UBES_RESP_OKAY = 2'h0;
   localparam logic [1:0] UBES_RESP_SLVERR = 2'h2;

   // Parity modes of the receiver
   typedef enum logic [1:0] {
      UBES_PAR_NONE = 2'h0,
      UBES_PAR_ZERO = 2'h1,
      UBES_PAR_ODD = 2'h2,
      UBES_PAR_EVEN = 2'h3
   } ubes_parity_t;

   // One received frame as handed over by the receive shifter
   typedef struct packed {
      logic [7:0] data;
      logic parity_bit;
      logic stop_bit;
   } ubes_rx_frame_t;

   // Byte address of a register index
   function automatic logic [17:0] ubes_byte_addr(input logic [15:0] idx);
      ubes_byte_addr = {idx, 2'b00};
   endfunction

endpackage

// file: rtl/ubes_brg.sv
// Baud generator: prescaler or external pin clock, then divide by sixteen.
// Assumes the pin clock is far slower than the system clock.
`timescale 1ns/1ps
`default_nettype none
module ubes_brg
   import ubes_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic [3:0] i_sel,
   input wire logic i_restart,
   input wire logic i_ext_clk,
   output logic o_tick16,
   output logic o_tick_bit
);

   logic [7:0] presc_r;
   logic ext_s1_r;
   logic ext_s2_r;
   logic ext_s3_r;
   logic half_r;
   logic [2:0] div8_r;

   // Mask of the low n bits, n being code plus one
   function automatic logic [7:0] presc_mask(input logic [3:0] sel);
      presc_mask = 8'(({1'b0, 8'hff} << ({1'b0, sel[2:0]} + 4'h1)) >> 9'h0) ^ 8'hff;
   endfunction

   wire logic sel_osc = (i_sel <= UBES_SEL_OSC_MAX);
   wire logic sel_ext = (i_sel == UBES_SEL_EXT);
   wire logic [7:0] mask = presc_mask(i_sel);
   // Oscillator over two to the n gives the sixteen-times tick
   wire logic osc_tick = sel_osc & ((presc_r & mask) == mask);
   // Each pin clock rise is one sixteenth of a bit
   wire logic ext_tick = sel_ext & ext_s2_r & ~ext_s3_r;
   // Codes outside the table yield no ticks at all
   wire logic tick = osc_tick | ext_tick;
   wire logic bit_done = tick & half_r & (div8_r == 3'h7);

   // Free prescaler; a restart keeps phases aligned after a reprogram
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         presc_r <= 8'h00;
      end else if (i_restart) begin
         presc_r <= 8'h00;
      end else begin
         presc_r <= presc_r + 8'h01;
      end
   end

   // Pin clock synchroniser and edge history
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_s3_r <= 1'b0;
      end else begin
         ext_s1_r <= i_ext_clk;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
      end
   end

   // Halver then divide-by-eight counter to the bit rate
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         half_r <= 1'b0;
         div8_r <= 3'h0;
      end else if (i_restart) begin
         half_r <= 1'b0;
         div8_r <= 3'h0;
      end else if (tick) begin
         half_r <= ~half_r;
         if (half_r) begin
            div8_r <= div8_r + 3'h1;
         end
      end
   end

   // Registered ticks
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_tick16 <= 1'b0;
         o_tick_bit <= 1'b0;
      end else begin
         o_tick16 <= tick & ~i_restart;
         o_tick_bit <= bit_done & ~i_restart;
      end
   end

endmodule // ubes_brg
`default_nettype wire

// file: rtl/ubes_top.sv
// Receive error status, baud control and interrupt logic behind AXI4-Lite.
// Assumes the receive shifter pulses I_RX_DONE with the frame on I_RX_FRAME.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module ubes_top
   import ubes_pkg::*;
#(
   parameter int ADDR_W = 20
) (
   input wire logic I_CLK,
   input wire logic I_RSTN,
   input wire logic [ADDR_W-1:0] I_AXI_AWADDR,
   input wire logic I_AXI_AWVALID,
   output logic O_AXI_AWREADY,
   input wire logic [31:0] I_AXI_WDATA,
   input wire logic [3:0] I_AXI_WSTRB,
   input wire logic I_AXI_WVALID,
   output logic O_AXI_WREADY,
   output logic [1:0] O_AXI_BRESP,
   output logic O_AXI_BVALID,
   input wire logic I_AXI_BREADY,
   input wire logic [ADDR_W-1:0] I_AXI_ARADDR,
   input wire logic I_AXI_ARVALID,
   output logic O_AXI_ARREADY,
   output logic [31:0] O_AXI_RDATA,
   output logic [1:0] O_AXI_RRESP,
   output logic O_AXI_RVALID,
   input wire logic I_AXI_RREADY,
   input wire logic I_RX_DONE,
   input wire ubes_rx_frame_t I_RX_FRAME,
   input wire logic I_EXT_BAUD_CLK,
   output logic O_BAUD_TICK16,
   output logic O_BAUD_TICK_BIT,
   output logic O_TX_ENABLE,
   output logic O_RX_ENABLE,
   output logic [1:0] O_PARITY_MODE,
   output logic O_CHAR_8BIT,
   output logic O_STOP_LENGTH,
   output logic O_IRQ
);

   // Refuse address widths that cannot reach the register indices
   if (ADDR_W < 18 || ADDR_W > 32) begin : g_bad_aw
      $error("ADDR_W must lie between 18 and 32");
   end

   // Bus-side state
   logic [ADDR_W-1:0] awaddr_r;
   logic [ADDR_W-1:0] awaddr_nxt;
   logic aw_held_r;
   logic [31:0] wdata_r;
   logic [31:0] wdata_nxt;
   logic [3:0] wstrb_r;
   logic [3:0] wstrb_nxt;
   logic w_held_r;

   // Block registers
   logic [2:0] status_r;
   logic [2:0] status_nxt;
   logic unread_r;
   logic unread_nxt;
   logic [7:0] rxbuf_r;
   logic [7:0] rxbuf_nxt;
   logic [3:0] baud_sel_r;
   logic [7:0] mode_r;
   logic [3:0] irq_stat_r;
   logic [3:0] irq_stat_nxt;
   logic [3:0] irq_mask_r;

   // Address decode of a word address against an index
   function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
      addr_hit = (addr[ADDR_W-1:2] == (ADDR_W-2)'(ubes_byte_addr(idx) >> 2));
   endfunction

   // Handshakes
   wire logic aw_take = I_AXI_AWVALID & O_AXI_AWREADY;
   wire logic w_take = I_AXI_WVALID & O_AXI_WREADY;
   wire logic ar_take = I_AXI_ARVALID & O_AXI_ARREADY;
   wire logic b_done = O_AXI_BVALID & I_AXI_BREADY;
   wire logic r_done = O_AXI_RVALID & I_AXI_RREADY;
   wire logic wr_go = aw_held_r & w_held_r & ~O_AXI_BVALID;

   // Write decode; the low byte lane must be present, and all four lanes for the baud register
   wire logic lane0 = wstrb_r[0];
   wire logic wr_mode = wr_go & lane0 & addr_hit(awaddr_r, UBES_IDX_MODE);
   wire logic wr_baud = wr_go & (wstrb_r == 4'hf) & addr_hit(awaddr_r, UBES_IDX_BAUD);
   wire logic wr_ist = wr_go & lane0 & addr_hit(awaddr_r, UBES_IDX_IRQ_STAT);
   wire logic wr_imask = wr_go & lane0 & addr_hit(awaddr_r, UBES_IDX_IRQ_MASK);
   // Status and buffer are read-only, so writes to them are refused
   wire logic wr_known = addr_hit(awaddr_r, UBES_IDX_MODE) | addr_hit(awaddr_r, UBES_IDX_BAUD)
      | addr_hit(awaddr_r, UBES_IDX_IRQ_STAT) | addr_hit(awaddr_r, UBES_IDX_IRQ_MASK);

   // Read decode
   wire logic rd_status = addr_hit(I_AXI_ARADDR, UBES_IDX_STATUS);
   wire logic rd_baud = addr_hit(I_AXI_ARADDR, UBES_IDX_BAUD);
   wire logic rd_mode = addr_hit(I_AXI_ARADDR, UBES_IDX_MODE);
   wire logic rd_rxbuf = addr_hit(I_AXI_ARADDR, UBES_IDX_RXBUF);
   wire logic rd_ist = addr_hit(I_AXI_ARADDR, UBES_IDX_IRQ_STAT);
   wire logic rd_imask = addr_hit(I_AXI_ARADDR, UBES_IDX_IRQ_MASK);
   wire logic rd_known = rd_status | rd_baud | rd_mode | rd_rxbuf | rd_ist | rd_imask;

   // Read data selection; upper status bits read zero
   wire logic [7:0] rd_byte = rd_status ? {5'h00, status_r} :
      rd_baud ? {baud_sel_r, 4'h0} :
      rd_mode ? mode_r :
      rd_rxbuf ? rxbuf_r :
      rd_ist ? {4'h0, irq_stat_r} :
      rd_imask ? {4'h0, irq_mask_r} : 8'h00;

   // Software reading the buffer is the buffer read strobe
   wire logic buf_read = ar_take & rd_rxbuf;

   // Receive event only while reception is enabled
   wire logic rx_ev = I_RX_DONE & mode_r[UBES_MD_RXE];
   wire ubes_parity_t par_mode = ubes_parity_t'(mode_r[UBES_MD_PS_LSB +: 2]);
   wire logic [7:0] rx_data = mode_r[UBES_MD_CL] ? I_RX_FRAME.data : {1'b0, I_RX_FRAME.data[6:0]};
   wire logic ones_odd = (^rx_data) ^ I_RX_FRAME.parity_bit;
   // Zero parity and no parity never flag an error
   wire logic par_err = ((par_mode == UBES_PAR_EVEN) & ones_odd)
      | ((par_mode == UBES_PAR_ODD) & ~ones_odd);
   // Only the first stop bit is looked at, whatever the stop length
   wire logic frm_err = ~I_RX_FRAME.stop_bit;
   // A buffer read in the same cycle counts as reading the old byte
   wire logic ovr_err = unread_r & ~buf_read;

   // Error flags, buffer and unread marker
   always_comb begin
      status_nxt = status_r;
      unread_nxt = unread_r;
      rxbuf_nxt = rxbuf_r;
      if (rx_ev) begin
         status_nxt = {par_err, frm_err, ovr_err};
         unread_nxt = 1'b1;
         rxbuf_nxt = rx_data;
      end else if (buf_read) begin
         status_nxt = UBES_RST_STATUS[2:0];
         unread_nxt = 1'b0;
      end
   end

   // Sticky interrupt bits; a new event wins over a clear
   wire logic [3:0] irq_ev = {rx_ev & ovr_err, rx_ev & frm_err, rx_ev & par_err, rx_ev};
   wire logic [3:0] irq_clr = wr_ist ? wdata_r[3:0] : 4'h0;
   assign irq_stat_nxt = irq_ev | (irq_stat_r & ~irq_clr);

   // Captured write address and data
   assign awaddr_nxt = aw_take ? I_AXI_AWADDR : awaddr_r;
   assign wdata_nxt = w_take ? I_AXI_WDATA : wdata_r;
   assign wstrb_nxt = w_take ? I_AXI_WSTRB : wstrb_r;

   // Write channel: address and data in either order
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         awaddr_r <= '0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         O_AXI_AWREADY <= 1'b0;
         O_AXI_WREADY <= 1'b0;
      end else begin
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         aw_held_r <= (aw_held_r | aw_take) & ~wr_go;
         w_held_r <= (w_held_r | w_take) & ~wr_go;
         // Ready again only once the response is gone
         O_AXI_AWREADY <= ~aw_held_r & ~aw_take & ~O_AXI_BVALID & ~wr_go;
         O_AXI_WREADY <= ~w_held_r & ~w_take & ~O_AXI_BVALID & ~wr_go;
      end
   end

   // Write response
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_AXI_BVALID <= 1'b0;
         O_AXI_BRESP <= UBES_RESP_OKAY;
      end else if (wr_go) begin
         O_AXI_BVALID <= 1'b1;
         O_AXI_BRESP <= wr_known ? UBES_RESP_OKAY : UBES_RESP_SLVERR;
      end else if (b_done) begin
         O_AXI_BVALID <= 1'b0;
      end
   end

   // Read channel: one read at a time, answer one cycle after the address
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_AXI_ARREADY <= 1'b0;
         O_AXI_RVALID <= 1'b0;
         O_AXI_RDATA <= 32'h0000_0000;
         O_AXI_RRESP <= UBES_RESP_OKAY;
      end else begin
         O_AXI_ARREADY <= ~O_AXI_RVALID & ~ar_take;
         if (ar_take) begin
            O_AXI_RVALID <= 1'b1;
            O_AXI_RDATA <= {24'h00_0000, rd_byte};
            O_AXI_RRESP <= rd_known ? UBES_RESP_OKAY : UBES_RESP_SLVERR;
         end else if (r_done) begin
            O_AXI_RVALID <= 1'b0;
         end
      end
   end

   // Error status, buffer and unread marker registers
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         status_r <= UBES_RST_STATUS[2:0];
         unread_r <= 1'b0;
         rxbuf_r <= UBES_RST_RXBUF;
      end else begin
         status_r <= status_nxt;
         unread_r <= unread_nxt;
         rxbuf_r <= rxbuf_nxt;
      end
   end

   // Baud control keeps only the select nibble; low bits stay zero
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         baud_sel_r <= UBES_RST_BAUD[7:4];
      end else if (wr_baud) begin
         baud_sel_r <= wdata_r[UBES_BD_SEL_LSB +: 4];
      end
   end

   // Mode register; reserved bits 1..0 are forced to zero
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         mode_r <= UBES_RST_MODE;
      end else if (wr_mode) begin
         mode_r <= {wdata_r[7:2], 2'b00};
      end
   end

   // Interrupt status, mask and output
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         irq_stat_r <= UBES_RST_IRQ;
         irq_mask_r <= UBES_RST_IRQ;
         O_IRQ <= 1'b0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         if (wr_imask) begin
            irq_mask_r <= wdata_r[3:0];
         end
         O_IRQ <= |(irq_stat_nxt & (wr_imask ? wdata_r[3:0] : irq_mask_r));
      end
   end

   // Mode fields to the shifters, all registered
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_TX_ENABLE <= 1'b0;
         O_RX_ENABLE <= 1'b0;
         O_PARITY_MODE <= UBES_PAR_NONE;
         O_CHAR_8BIT <= 1'b0;
         O_STOP_LENGTH <= 1'b0;
      end else begin
         O_TX_ENABLE <= mode_r[UBES_MD_TXE];
         O_RX_ENABLE <= mode_r[UBES_MD_RXE];
         O_PARITY_MODE <= mode_r[UBES_MD_PS_LSB +: 2];
         O_CHAR_8BIT <= mode_r[UBES_MD_CL];
         // Transmit side only; reception ignores it
         O_STOP_LENGTH <= mode_r[UBES_MD_SL];
      end
   end

   // Baud generator; a baud write with all four lanes restarts it, which is why writes mid-frame corrupt
   ubes_brg u_brg (
      .i_clk(I_CLK),
      .i_rstn(I_RSTN),
      .i_sel(baud_sel_r),
      .i_restart(wr_baud),
      .i_ext_clk(I_EXT_BAUD_CLK),
      .o_tick16(O_BAUD_TICK16),
      .o_tick_bit(O_BAUD_TICK_BIT)
   );

endmodule // ubes_top
`default_nettype wire

// file: tb/ubes_props.sv
// Checker for the serial error-status and baud block, bound to its top.
// Assumes byte addresses are four times the register index.
`timescale 1ns/1ps
`default_nettype none
module ubes_props
   import ubes_pkg::*;
#(
   parameter int ADDR_W = 20
) (
   input wire logic I_CLK,
   input wire logic I_RSTN,
   input wire logic [ADDR_W-1:0] I_AXI_AWADDR,
   input wire logic I_AXI_AWVALID,
   input wire logic O_AXI_AWREADY,
   input wire logic I_AXI_WVALID,
   input wire logic O_AXI_WREADY,
   input wire logic [1:0] O_AXI_BRESP,
   input wire logic O_AXI_BVALID,
   input wire logic [ADDR_W-1:0] I_AXI_ARADDR,
   input wire logic I_AXI_ARVALID,
   input wire logic O_AXI_ARREADY,
   input wire logic [31:0] O_AXI_RDATA,
   input wire logic O_AXI_RVALID,
   input wire logic O_BAUD_TICK16,
   input wire logic O_BAUD_TICK_BIT
);
   localparam logic [ADDR_W-1:0] A_ST = ADDR_W'({UBES_IDX_STATUS, 2'b00});
   localparam logic [ADDR_W-1:0] A_RX = ADDR_W'({UBES_IDX_RXBUF, 2'b00});
   logic rd_st_r;
   logic wr_ro_r;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RSTN);
   // Target of the access in flight; one of each kind at a time
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         rd_st_r <= 1'b0;
         wr_ro_r <= 1'b0;
      end else begin
         if (I_AXI_ARVALID && O_AXI_ARREADY) rd_st_r <= (I_AXI_ARADDR == A_ST);
         if (I_AXI_AWVALID && O_AXI_AWREADY) wr_ro_r <= (I_AXI_AWADDR == A_ST) || (I_AXI_AWADDR == A_RX);
      end
   end
   sequence s_wr_take;
      I_AXI_AWVALID && O_AXI_AWREADY && I_AXI_WVALID && O_AXI_WREADY;
   endsequence
   sequence s_rd_take;
      I_AXI_ARVALID && O_AXI_ARREADY;
   endsequence
   a_wr_answer: assert property (s_wr_take |-> ##2 O_AXI_BVALID)
      else $error("write response late");
   a_rd_answer: assert property (s_rd_take |=> O_AXI_RVALID)
      else $error("read data late");
   a_ro_refused: assert property ($rose(O_AXI_BVALID) && wr_ro_r |-> O_AXI_BRESP == UBES_RESP_SLVERR)
      else $error("read-only write accepted");
   a_status_zeros: assert property (O_AXI_RVALID && rd_st_r |-> O_AXI_RDATA[31:3] == '0)
      else $error("status upper bits set");
   a_wr_busy: assert property (O_AXI_BVALID |-> !O_AXI_AWREADY && !O_AXI_WREADY)
      else $error("write ready during response");
   a_rd_busy: assert property (O_AXI_RVALID |-> !O_AXI_ARREADY)
      else $error("read ready during response");
   a_tick_single: assert property (O_BAUD_TICK16 |=> !O_BAUD_TICK16)
      else $error("tick wider than one cycle");
   a_bit_gap: assert property (O_BAUD_TICK_BIT |=> !O_BAUD_TICK_BIT [*8])
      else $error("bit ticks too close");
endmodule // ubes_props
`default_nettype wire

// file: tb/ubes_partner.sv
// Far side stand-in: remote transmitter frames and external pin clock.
// Assumes send is called only from the bench's main process.
`timescale 1ns/1ps
`default_nettype none
module ubes_partner
   import ubes_pkg::*;
#(
   parameter int EXT_HALF = 10
) (
   input wire logic i_clk,
   input wire logic i_ext_run,
   output logic o_rx_done,
   output ubes_rx_frame_t o_rx_frame,
   output logic o_ext_clk
);
   int cnt_r;
   initial begin
      o_rx_done = 1'b0;
      o_rx_frame = '0;
      o_ext_clk = 1'b0;
      cnt_r = 0;
   end
   // Pin clock far slower than the system clock; rests low when off
   always @(posedge i_clk) begin
      if (!i_ext_run) begin
         cnt_r <= 0;
         o_ext_clk <= 1'b0;
      end else if (cnt_r == EXT_HALF - 1) begin
         cnt_r <= 0;
         o_ext_clk <= ~o_ext_clk;
      end else begin
         cnt_r <= cnt_r + 1;
      end
   end
   // One frame strobe; the bus is not held afterwards
   task automatic send(input logic [7:0] d, input logic p, input logic s);
      @(posedge i_clk);
      o_rx_done <= 1'b1;
      o_rx_frame <= {d, p, s};
      @(posedge i_clk);
      o_rx_done <= 1'b0;
      o_rx_frame <= ~{d, p, s};
   endtask
endmodule // ubes_partner
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the serial error-status and baud block.
// Assumes the partner model supplies frames and the pin clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ubes_pkg::*;
   localparam int ADDR_W = 20;
   localparam logic [19:0] A_MD = {2'b00, UBES_IDX_MODE, 2'b00};
   localparam logic [19:0] A_ST = {2'b00, UBES_IDX_STATUS, 2'b00};
   localparam logic [19:0] A_BD = {2'b00, UBES_IDX_BAUD, 2'b00};
   localparam logic [19:0] A_RX = {2'b00, UBES_IDX_RXBUF, 2'b00};
   localparam logic [19:0] A_IS = {2'b00, UBES_IDX_IRQ_STAT, 2'b00};
   localparam logic [19:0] A_IM = {2'b00, UBES_IDX_IRQ_MASK, 2'b00};
   logic I_CLK, I_RSTN, I_AXI_AWVALID, I_AXI_WVALID, I_AXI_BREADY, I_AXI_ARVALID, I_AXI_RREADY;
   logic I_RX_DONE, I_EXT_BAUD_CLK, O_AXI_AWREADY, O_AXI_WREADY, O_AXI_BVALID, O_AXI_ARREADY;
   logic O_AXI_RVALID, O_BAUD_TICK16, O_BAUD_TICK_BIT, O_TX_ENABLE, O_RX_ENABLE, O_CHAR_8BIT;
   logic O_STOP_LENGTH, O_IRQ, ext_run;
   logic [19:0] I_AXI_AWADDR, I_AXI_ARADDR;
   logic [31:0] I_AXI_WDATA, O_AXI_RDATA, rd;
   logic [3:0] I_AXI_WSTRB;
   logic [1:0] O_AXI_BRESP, O_AXI_RRESP, O_PARITY_MODE, rs;
   ubes_rx_frame_t I_RX_FRAME;
   int n_errors = 0;
   int num_checks = 0;
   int g;

   ubes_top #(.ADDR_W(ADDR_W)) u_ubes_top (.*);
   ubes_partner u_ubes_partner (.i_clk(I_CLK), .i_ext_run(ext_run), .o_rx_done(I_RX_DONE),
      .o_rx_frame(I_RX_FRAME), .o_ext_clk(I_EXT_BAUD_CLK));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Master holds each valid until its own ready edge
   task automatic axi_wr(input logic [19:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge I_CLK);
      I_AXI_AWADDR <= a;
      I_AXI_WDATA <= d;
      I_AXI_WSTRB <= s;
      I_AXI_AWVALID <= 1'b1;
      I_AXI_WVALID <= 1'b1;
      I_AXI_BREADY <= 1'b1;
      do begin
         @(posedge I_CLK);
         if (I_AXI_AWVALID && O_AXI_AWREADY) I_AXI_AWVALID <= 1'b0;
         if (I_AXI_WVALID && O_AXI_WREADY) I_AXI_WVALID <= 1'b0;
      end while (O_AXI_BVALID !== 1'b1);
      rs = O_AXI_BRESP;
      I_AXI_BREADY <= 1'b0;
   endtask
   task automatic axi_rd(input logic [19:0] a);
      @(posedge I_CLK);
      I_AXI_ARADDR <= a;
      I_AXI_ARVALID <= 1'b1;
      I_AXI_RREADY <= 1'b1;
      do begin
         @(posedge I_CLK);
         if (I_AXI_ARVALID && O_AXI_ARREADY) I_AXI_ARVALID <= 1'b0;
      end while (O_AXI_RVALID !== 1'b1);
      rd = O_AXI_RDATA;
      rs = O_AXI_RRESP;
      I_AXI_RREADY <= 1'b0;
   endtask
   task automatic rd_chk(input logic [19:0] a, input logic [31:0] exp);
      axi_rd(a);
      chk(rd, exp);
   endtask
   task automatic wr_ok(input logic [19:0] a, input logic [31:0] d);
      axi_wr(a, d, 4'hf);
      chk(32'(rs), 32'(UBES_RESP_OKAY));
   endtask
   // Clocks between two successive ticks; watchdog bounds the wait
   task automatic gap(input logic b);
      do @(posedge I_CLK); while ((b ? O_BAUD_TICK_BIT : O_BAUD_TICK16) !== 1'b1);
      g = 0;
      do begin
         @(posedge I_CLK);
         g++;
      end while ((b ? O_BAUD_TICK_BIT : O_BAUD_TICK16) !== 1'b1);
   endtask

   task automatic t_regs;
      rd_chk(A_ST, 32'h0000_0000);
      rd_chk(A_BD, 32'h0000_0000);
      axi_wr(A_ST, 32'h0000_0007, 4'hf);
      chk(32'(rs), 32'(UBES_RESP_SLVERR));
      rd_chk(A_ST, 32'h0000_0000);
      axi_rd(20'h0_0100);
      chk(32'(rs), 32'(UBES_RESP_SLVERR));
      axi_wr(A_BD, 32'h0000_0040, 4'h1);
      chk(32'(rs), 32'(UBES_RESP_OKAY));
      rd_chk(A_BD, 32'h0000_0000);
      $display("t_regs done");
   endtask
   // Receiver idle here, so even the fastest code disturbs no transfer
   task automatic t_ticks;
      for (int k = 0; k < 8; k++) begin
         wr_ok(A_BD, 32'(k) << 4);
         gap(1'b0);
         chk(32'(g), 32'(2 << k));
      end
      wr_ok(A_BD, 32'h0000_0040);
      rd_chk(A_BD, 32'h0000_0040);
      gap(1'b1);
      chk(32'(g), 32'h0000_0200);
      ext_run <= 1'b1;
      wr_ok(A_BD, 32'h0000_0080);
      gap(1'b0);
      chk(32'(g), 32'h0000_0014);
      gap(1'b1);
      chk(32'(g), 32'h0000_0140);
      ext_run <= 1'b0;
      // A code outside the table must leave the generator silent
      wr_ok(A_BD, 32'h0000_0090);
      g = 0;
      repeat (300) begin
         @(posedge I_CLK);
         if (O_BAUD_TICK16 !== 1'b0) g++;
      end
      chk(32'(g), 32'h0000_0000);
      $display("t_ticks done");
   endtask
   // Error flags, overrun chain and interrupt masking
   task automatic t_rx;
      wr_ok(A_IM, 32'h0000_000f);
      wr_ok(A_MD, 32'h0000_0078);
      rd_chk(A_MD, 32'h0000_0078);
      chk(32'({O_TX_ENABLE, O_RX_ENABLE, O_PARITY_MODE, O_CHAR_8BIT, O_STOP_LENGTH, 2'b00}), 32'h0000_0078);
      u_ubes_partner.send(8'h55, 1'b1, 1'b1);
      rd_chk(A_ST, 32'h0000_0004);
      rd_chk(A_IS, 32'h0000_0003);
      chk(32'(O_IRQ), 32'h0000_0001);
      wr_ok(A_IS, 32'h0000_000f);
      rd_chk(A_IS, 32'h0000_0000);
      chk(32'(O_IRQ), 32'h0000_0000);
      rd_chk(A_RX, 32'h0000_0055);
      rd_chk(A_ST, 32'h0000_0000);
      u_ubes_partner.send(8'h00, 1'b0, 1'b0);
      rd_chk(A_ST, 32'h0000_0002);
      u_ubes_partner.send(8'h00, 1'b0, 1'b1);
      rd_chk(A_ST, 32'h0000_0001);
      u_ubes_partner.send(8'h00, 1'b0, 1'b1);
      rd_chk(A_ST, 32'h0000_0001);
      rd_chk(A_RX, 32'h0000_0000);
      rd_chk(A_ST, 32'h0000_0000);
      wr_ok(A_MD, 32'h0000_007c);
      u_ubes_partner.send(8'h00, 1'b0, 1'b1);
      rd_chk(A_ST, 32'h0000_0000);
      chk(32'({O_TX_ENABLE, O_RX_ENABLE, O_PARITY_MODE, O_CHAR_8BIT, O_STOP_LENGTH, 2'b00}), 32'h0000_007c);
      rd_chk(A_RX, 32'h0000_0000);
      for (int pm = 0; pm < 4; pm++) begin
         wr_ok(A_MD, 32'h0000_0048 | (32'(pm) << 4));
         u_ubes_partner.send(8'h01, 1'b1, 1'b1);
         rd_chk(A_ST, (pm == 2) ? 32'h0000_0004 : 32'h0000_0000);
         rd_chk(A_RX, 32'h0000_0001);
      end
      wr_ok(A_IM, 32'h0000_0000);
      wr_ok(A_IS, 32'h0000_000f);
      u_ubes_partner.send(8'h01, 1'b1, 1'b1);
      rd_chk(A_IS, 32'h0000_0001);
      chk(32'(O_IRQ), 32'h0000_0000);
      wr_ok(A_IM, 32'h0000_0001);
      rd_chk(A_RX, 32'h0000_0001);
      chk(32'(O_IRQ), 32'h0000_0001);
      // Frames are ignored while reception is off
      wr_ok(A_MD, 32'h0000_0020);
      u_ubes_partner.send(8'h80, 1'b0, 1'b0);
      rd_chk(A_ST, 32'h0000_0000);
      rd_chk(A_RX, 32'h0000_0001);
      // Seven-bit odd parity; bit 7 of the frame is dropped
      wr_ok(A_MD, 32'h0000_0060);
      u_ubes_partner.send(8'h80, 1'b0, 1'b1);
      rd_chk(A_ST, 32'h0000_0004);
      u_ubes_partner.send(8'h80, 1'b1, 1'b0);
      rd_chk(A_ST, 32'h0000_0003);
      rd_chk(A_IS, 32'h0000_000f);
      rd_chk(A_RX, 32'h0000_0000);
      $display("t_rx done");
   endtask

   task automatic close_out;
      $display("checks=%0d mismatches=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   initial begin
      I_CLK = 1'b0;
      forever #20 I_CLK = ~I_CLK;
   end
   // Idle bus, reset held, then the tests in turn
   initial begin
      {I_RSTN, I_AXI_AWVALID, I_AXI_WVALID, I_AXI_BREADY, I_AXI_ARVALID, I_AXI_RREADY, ext_run} = '0;
      {I_AXI_AWADDR, I_AXI_ARADDR, I_AXI_WDATA, I_AXI_WSTRB} = '0;
      repeat (12) @(posedge I_CLK);
      I_RSTN <= 1'b1;
      repeat (2) @(posedge I_CLK);
      t_regs;
      t_ticks;
      t_rx;
      close_out;
   end
   // Hang guard, well past the expected run length
   initial begin
      #(40 * 40000);
      n_errors++;
      close_out;
   end
endmodule // testbench
bind ubes_top ubes_props #(.ADDR_W(ADDR_W)) u_ubes_props (.*);
`default_nettype wire
